// *** core/pusts_pkg.sv ***
// package of constants for the power-up strap sampler
package pusts_pkg;
	// configuration index/data port base addresses
	localparam logic [7:0] BASE_ADDR_DEFAULT = 8'h2e;
	localparam logic [7:0] BASE_ADDR_ALT = 8'h4e;
	// reset values of the latched straps (undriven pins read high)
	localparam logic STRAP_RESET_VALUE = 1'b1;
	// number of straps held, and their positions in the latched vector
	localparam int STRAP_COUNT = 6;
	localparam int POS_BASE = 0;
	localparam int POS_FLOAT = 1;
	localparam int POS_TREE = 2;
	localparam int POS_GENERAL = 3;
	localparam int POS_MAIN_RSV = 4;
	localparam int POS_STBY_RSV = 5;
	// cycles that straps are watched after reset release before the pins are freed
	localparam int SAMPLE_CYCLES = 4;
	localparam int CNT_W = 3;
endpackage

// *** core/pusts_strap_reg.sv ***
// per-bit strap latch holding the value captured at sampling time
`timescale 1ns/1ps
module pusts_strap_reg #(
	parameter int WIDTH = 6
) (
	input wire logic clk_sys,
	input wire logic rst_sync_n,
	input wire logic capture,
	input wire logic [WIDTH-1:0] pin_in,
	output logic [WIDTH-1:0] held
);
	typedef struct packed {
		logic [WIDTH-1:0] held;
	} pusts_reg_state_t;
	pusts_reg_state_t state;
	pusts_reg_state_t next_state;

	// load the pin levels only while capture is high
	always_comb begin
		next_state = state;
		for (int i = 0; i < WIDTH; i++) begin
			if (capture) begin
				next_state.held[i] = pin_in[i];
			end
		end
	end

	// reset leaves every strap at its undriven level
	always_ff @(posedge clk_sys or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			state <= '{held: {WIDTH{pusts_pkg::STRAP_RESET_VALUE}}};
		end else begin
			state <= next_state;
		end
	end

	assign held = state.held;
endmodule // pusts_strap_reg

// *** core/pusts_sampler.sv ***
// power-up strap sampler: captures straps and applies base address, float and tree test
`timescale 1ns/1ps
module pusts_sampler #(
	parameter int CHAIN_W = 16
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic base_address_strap,
	input wire logic float_pins_strap,
	input wire logic tree_check_strap,
	input wire logic main_general_strap,
	input wire logic main_reserved_strap,
	input wire logic standby_reserved_strap,
	input wire logic [CHAIN_W-1:0] chain_pins,
	output logic [7:0] config_index_addr,
	output logic [7:0] config_data_addr,
	output logic float_pins,
	output logic tree_mode,
	output logic general_strap,
	output logic sampling_done,
	output logic serial_pins_enable,
	output logic chain_out,
	output logic chain_out_oe
);
	// ----------------------------------------------------------------
	// reset release
	// ----------------------------------------------------------------
	logic [1:0] rst_pipe;
	logic rst_sync_n;

	// two-stage release of the asynchronous power-up reset
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			rst_pipe <= 2'b00;
		end else begin
			rst_pipe <= {rst_pipe[0], 1'b1};
		end
	end
	assign rst_sync_n = rst_pipe[1];

	// ----------------------------------------------------------------
	// sampling sequencer
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		PUSTS_SAMPLE = 2'b01,
		PUSTS_HOLD = 2'b10
	} pusts_phase_t;

	typedef struct packed {
		pusts_phase_t phase;
		logic [pusts_pkg::CNT_W-1:0] cnt;
		logic chain;
	} pusts_state_t;

	pusts_state_t state;
	pusts_state_t next_state;
	logic capture;
	logic [pusts_pkg::STRAP_COUNT-1:0] pin_vec;
	logic [pusts_pkg::STRAP_COUNT-1:0] held;

	// watch the straps for a few cycles, then lock them and free the pins
	always_comb begin
		next_state = state;
		next_state.chain = ^chain_pins;
		unique case (state.phase)
			PUSTS_SAMPLE: begin
				if (state.cnt == pusts_pkg::CNT_W'(pusts_pkg::SAMPLE_CYCLES - 1)) begin
					next_state.phase = PUSTS_HOLD;
				end else begin
					next_state.cnt = state.cnt + 1'b1;
				end
			end
			PUSTS_HOLD: begin
				next_state.cnt = state.cnt;
			end
		endcase
	end

	always_ff @(posedge clk_sys or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			state <= '{phase: PUSTS_SAMPLE, cnt: '0, chain: 1'b0};
		end else begin
			state <= next_state;
		end
	end

	assign capture = (state.phase == PUSTS_SAMPLE);

	// ----------------------------------------------------------------
	// strap capture
	// ----------------------------------------------------------------
	always_comb begin
		pin_vec = '0;
		pin_vec[pusts_pkg::POS_BASE] = base_address_strap;
		pin_vec[pusts_pkg::POS_FLOAT] = float_pins_strap;
		pin_vec[pusts_pkg::POS_TREE] = tree_check_strap;
		pin_vec[pusts_pkg::POS_GENERAL] = main_general_strap;
		pin_vec[pusts_pkg::POS_MAIN_RSV] = main_reserved_strap;
		pin_vec[pusts_pkg::POS_STBY_RSV] = standby_reserved_strap;
	end

	pusts_strap_reg #(
		.WIDTH(pusts_pkg::STRAP_COUNT)
	) u_strap_reg (
		.clk_sys(clk_sys),
		.rst_sync_n(rst_sync_n),
		.capture(capture),
		.pin_in(pin_vec),
		.held(held)
	);

	// ----------------------------------------------------------------
	// applied configuration
	// ----------------------------------------------------------------
	// base pair selected by the latched address strap
	assign config_index_addr = held[pusts_pkg::POS_BASE] ? pusts_pkg::BASE_ADDR_DEFAULT
		: pusts_pkg::BASE_ADDR_ALT;
	assign config_data_addr = config_index_addr | 8'h01;
	// float wins if the board breaks the one-low-only arrangement
	assign float_pins = !held[pusts_pkg::POS_FLOAT];
	assign tree_mode = !held[pusts_pkg::POS_TREE] && held[pusts_pkg::POS_FLOAT];
	assign general_strap = held[pusts_pkg::POS_GENERAL];
	assign sampling_done = (state.phase == PUSTS_HOLD);
	// serial outputs stay off while sampling, in test and while floating
	assign serial_pins_enable = sampling_done && !float_pins && !tree_mode;
	assign chain_out = tree_mode ? state.chain : 1'b0;
	assign chain_out_oe = sampling_done && tree_mode && !float_pins;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	property p_base_sel;
		@(posedge clk_sys) disable iff (!rst_sync_n)
		sampling_done |-> (config_index_addr == (held[0] ? 8'h2e : 8'h4e));
	endproperty
	a_base_sel: assert property (p_base_sel) else $error("wrong base address");

	property p_float;
		@(posedge clk_sys) disable iff (!rst_sync_n)
		float_pins |-> !serial_pins_enable && !chain_out_oe;
	endproperty
	a_float: assert property (p_float) else $error("pin driven while floating");

	property p_tree;
		@(posedge clk_sys) disable iff (!rst_sync_n)
		(sampling_done && !held[2] && held[1]) |-> tree_mode && chain_out_oe;
	endproperty
	a_tree: assert property (p_tree) else $error("tree mode not entered");

	property p_chain;
		@(posedge clk_sys) disable iff (!rst_sync_n)
		tree_mode ##1 tree_mode |-> chain_out == $past(^chain_pins);
	endproperty
	a_chain: assert property (p_chain) else $error("chain result wrong");

	property p_general;
		@(posedge clk_sys) disable iff (!rst_sync_n)
		sampling_done |-> general_strap == held[3];
	endproperty
	a_general: assert property (p_general) else $error("general strap wrong");

	property p_done_time;
		@(posedge clk_sys) disable iff (!rst_sync_n)
		$rose(rst_sync_n) |-> !sampling_done [*4] ##1 sampling_done;
	endproperty
	a_done_time: assert property (p_done_time) else $error("sampling length wrong");

	property p_serial_wait;
		@(posedge clk_sys) disable iff (!rst_sync_n)
		!sampling_done |-> !serial_pins_enable;
	endproperty
	a_serial_wait: assert property (p_serial_wait) else $error("serial early");

	property p_hold;
		@(posedge clk_sys) disable iff (!rst_sync_n)
		sampling_done ##1 sampling_done |-> $stable(held);
	endproperty
	a_hold: assert property (p_hold) else $error("straps changed after lock");

	property p_reserved;
		@(posedge clk_sys) disable iff (!rst_sync_n)
		sampling_done ##1 sampling_done |-> $stable(config_index_addr) && $stable(float_pins);
	endproperty
	a_reserved: assert property (p_reserved) else $error("config moved");

	// once locked the block stays locked until the next power-up reset
	property p_done_stays;
		@(posedge clk_sys) disable iff (!rst_sync_n)
		sampling_done |=> sampling_done;
	endproperty
	a_done_stays: assert property (p_done_stays) else $error("lock lost");

	// data port always sits one above the index port
	property p_data_pair;
		@(posedge clk_sys) disable iff (!rst_sync_n)
		sampling_done |-> config_data_addr == (config_index_addr + 8'h01);
	endproperty
	a_data_pair: assert property (p_data_pair) else $error("data port wrong");

	// no strap is taken once the pins are handed back
	property p_no_late_capture;
		@(posedge clk_sys) disable iff (!rst_sync_n)
		sampling_done |-> !capture;
	endproperty
	a_no_late_capture: assert property (p_no_late_capture) else $error("late capture");

	// chain output is silent outside test mode
	property p_chain_quiet;
		@(posedge clk_sys) disable iff (!rst_sync_n)
		!tree_mode |-> !chain_out && !chain_out_oe;
	endproperty
	a_chain_quiet: assert property (p_chain_quiet) else $error("chain out of test");

	// shared base-address pin is not driven while straps are still read
	property p_chain_late;
		@(posedge clk_sys) disable iff (!rst_sync_n)
		!sampling_done |-> !chain_out_oe;
	endproperty
	a_chain_late: assert property (p_chain_late) else $error("chain drive early");

	// floating overrides the tree test when both straps read low
	property p_float_wins;
		@(posedge clk_sys) disable iff (!rst_sync_n)
		float_pins |-> !tree_mode;
	endproperty
	a_float_wins: assert property (p_float_wins) else $error("tree while floating");
endmodule // pusts_sampler

// *** tb/pusts_board.sv ***
// board model: strap resistors plus serial drivers sharing the strap pins
`timescale 1ns/1ps
module pusts_board (
	input wire logic clk_sys,
	input wire logic [5:0] pull_down,
	input wire logic serial_pins_enable,
	output logic [5:0] strap
);
	logic [5:0] pattern = 6'h15;
	// freed serial outputs toggle every cycle so a late sample sees junk
	always_ff @(posedge clk_sys) begin
		pattern <= ~pattern;
	end
	// open strap reads high via pull-up, fitted pull-down reads low
	always_comb begin
		strap = serial_pins_enable ? pattern : ~pull_down;
	end
endmodule // pusts_board

// *** tb/pusts_sampler_tb.sv ***
// self-checking bench for the power-up strap sampler
`timescale 1ns/1ps
module pusts_sampler_tb;
	logic clk_sys = 1'b0;
	logic rst_n = 1'b0;
	logic [5:0] pull_down = 6'h00;
	logic [5:0] strap;
	logic [15:0] chain_pins = 16'h0001;
	logic [7:0] idx;
	logic [7:0] dat;
	logic flt, tree, gen, done, ser, cout, coe;
	int n_errors = 0;
	int checked = 0;
	// rows: fitted pull-downs, then {index addr, float, tree, general, serial, chain oe}
	logic [5:0] pd_row [5] = '{6'h00, 6'h09, 6'h12, 6'h30, 6'h04};
	logic [12:0] exp_row [5] = '{13'h05c6, 13'h09c2, 13'h05d4, 13'h05c6, 13'h05cd};

	// ----------------------------------------
	// clock, design and board
	// ----------------------------------------
	initial begin
		forever #12.5 clk_sys = ~clk_sys;
	end
	pusts_sampler #(.CHAIN_W(16)) u_pusts_sampler (
		.clk_sys(clk_sys), .rst_n(rst_n),
		.base_address_strap(strap[0]), .float_pins_strap(strap[1]),
		.tree_check_strap(strap[2]), .main_general_strap(strap[3]),
		.main_reserved_strap(strap[4]), .standby_reserved_strap(strap[5]),
		.chain_pins(chain_pins), .config_index_addr(idx), .config_data_addr(dat),
		.float_pins(flt), .tree_mode(tree), .general_strap(gen),
		.sampling_done(done), .serial_pins_enable(ser),
		.chain_out(cout), .chain_out_oe(coe)
	);
	pusts_board u_pusts_board (
		.clk_sys(clk_sys), .pull_down(pull_down),
		.serial_pins_enable(ser), .strap(strap)
	);

	// ----------------------------------------
	// compare, reset and closing tasks
	// ----------------------------------------
	task automatic report_and_stop();
		$display("errors %0d checks %0d", n_errors, checked);
		if (n_errors == 0 && checked > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	task automatic chk_cfg(input logic [12:0] got, input logic [12:0] exp);
		checked++;
		if (got !== exp) begin
			n_errors++;
			$display("mismatch at %0t: config %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chk_bit(input logic got, input logic exp);
		checked++;
		if (got !== exp) begin
			n_errors++;
			$display("mismatch at %0t: bit %b expected %b", $time, got, exp);
		end
	endtask
	// power-up with given pull-downs, wait a bounded time for lock
	task automatic power_up(input logic [5:0] pd);
		int i;
		@(negedge clk_sys);
		rst_n = 1'b0;
		pull_down = pd;
		repeat (10) @(negedge clk_sys);
		rst_n = 1'b1;
		for (i = 0; i < 40 && done !== 1'b1; i++) begin
			@(negedge clk_sys);
		end
		if (done !== 1'b1) begin
			n_errors++;
			report_and_stop();
		end
	endtask

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		for (int r = 0; r < 5; r++) begin
			power_up(pd_row[r]);
			chk_cfg({idx, flt, tree, gen, ser, coe}, exp_row[r]);
			chk_cfg({dat, 5'h00}, {exp_row[r][12:5] + 8'h01, 5'h00});
			chk_bit(cout, exp_row[r][3]);
			pull_down = ~pd_row[r];
			repeat (3) @(negedge clk_sys);
			chk_cfg({idx, flt, tree, gen, ser, coe}, exp_row[r]);
		end
		// still in tree mode: chain output follows the xor of all pins
		chain_pins = 16'ha5c3;
		repeat (2) @(negedge clk_sys);
		chk_bit(cout, 1'b0);
		chain_pins = 16'h8000;
		repeat (2) @(negedge clk_sys);
		chk_bit(cout, 1'b1);
		// reset in mid-run drops locked values back to reset state
		power_up(6'h01);
		chk_cfg({idx, flt, tree, gen, ser, coe}, 13'h09c6);
		@(negedge clk_sys);
		rst_n = 1'b0;
		@(negedge clk_sys);
		chk_cfg({idx, flt, tree, gen, ser, coe}, 13'h05c4);
		chk_bit(done, 1'b0);
		report_and_stop();
	end
endmodule // pusts_sampler_tb
